// file: hdl/auc_cfg.svh
`ifndef AUC_CFG_SVH
`define AUC_CFG_SVH
// ---------------------------------------------------------------
// command encodings and link constants
// ---------------------------------------------------------------
`define AUC_SYNC_BYTE 8'h55
`define AUC_CMD_RESET 8'h06
`define AUC_CMD_START 8'h08
`define AUC_CMD_SLEEP 8'h02
`define AUC_NIB_RDATA 4'h1
`define AUC_NIB_RREG 4'h2
`define AUC_NIB_WREG 4'h4
`define AUC_REG_NO_RESTART 3'h4
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define AUC_CLK_HZ 25000000
`define AUC_CLK_PS 40000
`define AUC_TCLK_NORM_PS 976563
`define AUC_TCLK_TURBO_PS 488281
`define AUC_START_NORM_X10 285
`define AUC_START_TURBO_X10 1050
`define AUC_FMOD_NORM_HZ 256000
`define AUC_FMOD_TURBO_HZ 512000
`define AUC_TMOD_NORM_PS 3906250
`define AUC_TMOD_TURBO_PS 1953125
`define AUC_TO_NORM_TMOD 32760
`define AUC_TO_TURBO_TMOD 65520
`define AUC_RESULT_READY_N_PULSE_TCLK 2
`endif

// file: hdl/auc_pkg.sv
package auc_pkg;
  // receive sequencer
  typedef enum logic [2:0] {
    AUC_R_IDLE = 3'b000,
    AUC_R_SYNC = 3'b001,
    AUC_R_START = 3'b010,
    AUC_R_BITS = 3'b011,
    AUC_R_STOP = 3'b100
  } auc_rx_st_t;
  // conversion sequencer
  typedef enum logic [1:0] {
    AUC_C_SLEEP = 2'b00,
    AUC_C_DELAY = 2'b01,
    AUC_C_RUN = 2'b10
  } auc_cv_st_t;
  // register access request toward the register file
  typedef struct packed {
    logic stb;
    logic [2:0] addr;
    logic [7:0] data;
  } auc_reg_req_t;
  // finished conversion from the modulator/filter
  typedef struct packed {
    logic done;
    logic [15:0] data;
  } auc_result_t;
endpackage

// file: hdl/auc_tx.sv
`timescale 1ns/100ps
`default_nettype none
`include "auc_cfg.svh"
module auc_tx #(
  parameter int CW = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [CW-1:0] bit_len,
  input wire logic go,
  input wire logic [7:0] byte_in,
  output logic ready,
  output logic txd
);
  logic busy_q;
  logic txd_q;
  logic [8:0] sh_q;
  logic [3:0] n_q;
  logic [CW-1:0] cnt_q;

  assign ready = ~busy_q;
  assign txd = txd_q;

  // ---------------------------------------------------------------
  // serializer
  // ---------------------------------------------------------------
  // start bit, eight data bits lsb first, one stop bit
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      txd_q <= 1'b1;
      sh_q <= 9'h1ff;
      n_q <= 4'h0;
      cnt_q <= '0;
    end else if (!busy_q) begin
      txd_q <= 1'b1; // line idles high
      if (go) begin
        busy_q <= 1'b1;
        txd_q <= 1'b0;
        sh_q <= {1'b1, byte_in};
        n_q <= 4'h0;
        cnt_q <= '0;
      end
    end else if (cnt_q + 1'b1 >= bit_len) begin
      cnt_q <= '0;
      if (n_q == 4'h9) begin
        busy_q <= 1'b0;
        txd_q <= 1'b1;
      end else begin
        txd_q <= sh_q[0];
        sh_q <= {1'b1, sh_q[8:1]};
        n_q <= n_q + 4'h1;
      end
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  frame_stop_a: assert property (@(posedge clk) disable iff (rst)
    $fell(busy_q) |-> txd_q && $past(txd_q))
    else $error("stop bit not high at end of frame");
endmodule
`default_nettype wire

// file: hdl/auc_ctrl.sv
// Overview of operation
// - reset command bytes reset whole device
// - mode bit takes effect at next start
// - single-shot: one conversion, then low power
// - register write except 04h restarts conversion
// - continuous: buffer result, restart at once
// - first continuous start after fixed delay
// - normal mode modulator at 256 kHz
// - turbo mode modulator at 512 kHz
// - sleep finishes conversion, powers analog down
// - start wakes device in selected mode
// - receive line is never driven
// - transmit line idles high
// - result ready falls on data, rises latched
// - unread result, continuous mode with auto read off: brief high pulse, fall again
// - frames are start, eight data, stop
// - sync byte 55h precedes every command
// - idle timeout resets the receive interface
// - results are 16-bit two's complement
// - command latched mid stop bit
// - start command is 0000 100x
// - sleep command is 0000 001x
// - words go lsb byte first
`timescale 1ns/100ps
`default_nettype none
`include "auc_cfg.svh"
module auc_ctrl import auc_pkg::*; #(
  parameter int CW = 20,
  parameter int unsigned TO_NORM_CYC = int'((64'(`AUC_TO_NORM_TMOD)
    * 64'(`AUC_TMOD_NORM_PS)) / 64'(`AUC_CLK_PS)),
  parameter int unsigned TO_TURBO_CYC = int'((64'(`AUC_TO_TURBO_TMOD)
    * 64'(`AUC_TMOD_TURBO_PS)) / 64'(`AUC_CLK_PS))
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic conversion_mode_select,
  input wire logic turbo_mode,
  input wire logic auto_read,
  input wire logic [2:0] rate_select,
  input wire logic general_io_pin_two_dir,
  input wire logic general_io_pin_two_out,
  input wire logic shared_pin_function_select,
  input wire auc_result_t conv_result,
  output logic conv_start,
  output logic [2:0] conv_rate,
  output logic conv_turbo,
  output logic analog_power_en,
  output logic osc_en,
  output logic excitation_current_source_en,
  output logic mod_tick,
  output logic result_ready_n,
  output logic general_io_pin_two_o,
  output logic general_io_pin_two_oe,
  output auc_reg_req_t reg_wr,
  output auc_reg_req_t reg_rd,
  input wire logic [7:0] reg_rd_data,
  output logic cfg_reset
);
  // least times round up, longest down
  localparam int START_NORM_CYC = (`AUC_START_NORM_X10 * `AUC_TCLK_NORM_PS
    + 10 * `AUC_CLK_PS - 1) / (10 * `AUC_CLK_PS);
  localparam int START_TURBO_CYC = (`AUC_START_TURBO_X10 * `AUC_TCLK_TURBO_PS
    + 10 * `AUC_CLK_PS - 1) / (10 * `AUC_CLK_PS);
  localparam int PULSE_CYC = `AUC_RESULT_READY_N_PULSE_TCLK * `AUC_TCLK_NORM_PS / `AUC_CLK_PS;

  // lsb of the single-byte commands is a don't-care
  function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] c);
    cmd_is = (b[7:1] == c[7:1]);
  endfunction

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  logic [2:0] pin_sh_q;
  logic pin_lvl_q;
  logic cmd_rst_q;
  logic rst_all;

  // pin passes three flops; level moves once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_sh_q <= 3'b111;
      pin_lvl_q <= 1'b1;
    end else begin
      pin_sh_q <= {pin_sh_q[1:0], reset_pin_n};
      if (pin_sh_q[1] == pin_sh_q[2]) begin
        pin_lvl_q <= pin_sh_q[2]; // held low resets
      end
    end
  end

  assign rst_all = sys_rst | ~pin_lvl_q | cmd_rst_q;

  // config registers outside are cleared by any reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reset <= 1'b1;
    end else begin
      cfg_reset <= rst_all;
    end
  end

  // ---------------------------------------------------------------
  // receive line conditioning
  // ---------------------------------------------------------------
  logic [2:0] rx_sh_q;
  logic rx_lvl_q;
  logic rx_prev_q;
  logic rx_fall;
  logic rx_edge;

  // input only: this side never drives the receive line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sh_q <= 3'b111;
      rx_lvl_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_sh_q <= {rx_sh_q[1:0], rx_pin};
      if (rx_sh_q[1] == rx_sh_q[2]) begin
        rx_lvl_q <= rx_sh_q[2];
      end
      rx_prev_q <= rx_lvl_q;
    end
  end

  assign rx_fall = rx_prev_q & ~rx_lvl_q;
  assign rx_edge = rx_prev_q ^ rx_lvl_q;

  // ---------------------------------------------------------------
  // receiver with baud measurement
  // ---------------------------------------------------------------
  auc_rx_st_t rst_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] tgt_q;
  logic [CW-1:0] bit_q;
  logic [2:0] nfall_q;
  logic [2:0] idx_q;
  logic [7:0] sh_q;
  logic sync_q;
  logic rx_stb_q;
  logic [7:0] rx_byte_q;
  logic [22:0] to_q;
  logic to_hit;
  logic [CW-1:0] span;
  logic cmd_done;
  logic wreg_pend_q;
  logic [2:0] wreg_addr_q;

  // idle timer restarts on every line edge; same wall time in both modes
  always_ff @(posedge clk) begin
    if (rst_all || rst_q == AUC_R_IDLE || rx_edge) begin
      to_q <= '0;
    end else if (!to_hit) begin
      to_q <= to_q + 23'd1;
    end
  end

  assign to_hit = to_q == (turbo_mode ? 23'(TO_TURBO_CYC) : 23'(TO_NORM_CYC));

  // first-to-fifth fall spans the count plus the closing cycle
  assign span = cnt_q + 1'b1;

  // a byte that completes a command sends the receiver back to hunting
  assign cmd_done = rx_stb_q &
    (wreg_pend_q | (rx_byte_q[7:4] != `AUC_NIB_WREG));

  always_ff @(posedge clk) begin
    if (rst_all || to_hit) begin
      rst_q <= AUC_R_IDLE; // interface reset on timeout
      sync_q <= 1'b0;
      rx_stb_q <= 1'b0;
      cnt_q <= '0;
      tgt_q <= '0;
      nfall_q <= 3'd0;
      idx_q <= 3'd0;
    end else begin
      rx_stb_q <= 1'b0;
      case (rst_q)
        AUC_R_IDLE: begin
          if (rx_fall) begin
            rst_q <= AUC_R_SYNC; // every command opens with sync
            cnt_q <= '0;
            nfall_q <= 3'd0;
          end
        end
        AUC_R_SYNC: begin
          cnt_q <= cnt_q + 1'b1;
          if (rx_fall) begin
            nfall_q <= nfall_q + 3'd1;
            // fifth falling edge of 55h lies eight bits after the first
            if (nfall_q == 3'd3) begin
              bit_q <= {3'b000, span[CW-1:3]};
              tgt_q <= {4'b0000, span[CW-1:4]};
              cnt_q <= '0;
              idx_q <= 3'd7;
              sync_q <= 1'b1;
              rst_q <= AUC_R_BITS;
            end
          end
        end
        AUC_R_START: begin
          if (cmd_done) begin
            rst_q <= AUC_R_IDLE;
          end else if (rx_fall) begin
            cnt_q <= '0;
            tgt_q <= bit_q + (bit_q >> 1);
            idx_q <= 3'd0;
            rst_q <= AUC_R_BITS;
          end
        end
        AUC_R_BITS: begin
          if (cnt_q == tgt_q) begin
            sh_q <= {rx_lvl_q, sh_q[7:1]}; // lsb arrives first
            cnt_q <= CW'(1); // hit cycle counts, else samples drift a cycle per bit
            tgt_q <= bit_q;
            idx_q <= idx_q + 3'd1;
            if (idx_q == 3'd7) begin
              rst_q <= AUC_R_STOP;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        AUC_R_STOP: begin
          if (cnt_q == tgt_q) begin
            cnt_q <= '0;
            if (!rx_lvl_q) begin
              rst_q <= AUC_R_IDLE; // framing error drops the transaction
            end else begin
              rst_q <= AUC_R_START;
              sync_q <= 1'b0;
              rx_stb_q <= ~sync_q; // latched mid stop bit
              rx_byte_q <= sh_q;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: rst_q <= AUC_R_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic start_cmd_q;
  logic sleep_cmd_q;
  logic rdata_q;
  logic wr_restart;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      cmd_rst_q <= 1'b0;
      start_cmd_q <= 1'b0;
      sleep_cmd_q <= 1'b0;
      rdata_q <= 1'b0;
      wreg_pend_q <= 1'b0;
      wreg_addr_q <= 3'd0;
      reg_wr <= '0;
      reg_rd <= '0;
    end else begin
      start_cmd_q <= 1'b0;
      sleep_cmd_q <= 1'b0;
      rdata_q <= 1'b0;
      reg_wr.stb <= 1'b0;
      reg_rd.stb <= 1'b0;
      if (rx_stb_q && wreg_pend_q) begin
        reg_wr <= '{stb: 1'b1, addr: wreg_addr_q, data: rx_byte_q};
        wreg_pend_q <= 1'b0;
      end else if (rx_stb_q) begin
        cmd_rst_q <= cmd_is(rx_byte_q, `AUC_CMD_RESET);
        start_cmd_q <= cmd_is(rx_byte_q, `AUC_CMD_START);
        sleep_cmd_q <= cmd_is(rx_byte_q, `AUC_CMD_SLEEP);
        rdata_q <= rx_byte_q[7:4] == `AUC_NIB_RDATA;
        if (rx_byte_q[7:4] == `AUC_NIB_RREG) begin
          reg_rd <= '{stb: 1'b1, addr: rx_byte_q[3:1], data: 8'h00};
        end
        if (rx_byte_q[7:4] == `AUC_NIB_WREG) begin
          wreg_pend_q <= 1'b1;
          wreg_addr_q <= rx_byte_q[3:1];
        end
      end else if (rst_q == AUC_R_IDLE) begin
        wreg_pend_q <= 1'b0; // half-finished write is abandoned
      end
    end
  end

  assign wr_restart = reg_wr.stb && (reg_wr.addr != `AUC_REG_NO_RESTART);

  // ---------------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------------
  auc_cv_st_t cst_q;
  logic [10:0] dly_q;
  logic [10:0] dly_lim;
  logic cm_act_q;
  logic sleep_pend_q;
  logic pd_q;

  assign dly_lim = turbo_mode ? 11'(START_TURBO_CYC) : 11'(START_NORM_CYC);

  always_ff @(posedge clk) begin
    if (rst_all) begin
      cst_q <= AUC_C_SLEEP;
      dly_q <= 11'd0;
      cm_act_q <= 1'b0;
      sleep_pend_q <= 1'b0;
      pd_q <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (start_cmd_q) begin
        // mode bit sampled only here
        cm_act_q <= conversion_mode_select;
        sleep_pend_q <= 1'b0;
        pd_q <= 1'b0; // wakes from power-down
        dly_q <= 11'd0;
        if (conversion_mode_select) begin
          cst_q <= AUC_C_DELAY;
        end else begin
          cst_q <= AUC_C_RUN;
          conv_start <= 1'b1;
        end
      end else if (sleep_cmd_q) begin
        if (cst_q == AUC_C_RUN) begin
          sleep_pend_q <= 1'b1; // let conversion finish
        end else begin
          cst_q <= AUC_C_SLEEP;
          pd_q <= 1'b1;
        end
      end else begin
        case (cst_q)
          AUC_C_DELAY: begin
            if (dly_q == dly_lim - 11'd1) begin
              conv_start <= 1'b1;
              cst_q <= AUC_C_RUN;
            end else begin
              dly_q <= dly_q + 11'd1;
            end
          end
          AUC_C_RUN: begin
            if (wr_restart) begin
              conv_start <= 1'b1; // abort and restart
            end else if (conv_result.done) begin
              if (cm_act_q && !sleep_pend_q) begin
                conv_start <= 1'b1;
              end else begin
                cst_q <= AUC_C_SLEEP;
                pd_q <= sleep_pend_q;
                sleep_pend_q <= 1'b0;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // rate and speed are frozen per conversion
  always_ff @(posedge clk) begin
    if (rst_all) begin
      conv_rate <= 3'd0;
      conv_turbo <= 1'b0;
    end else if (conv_start) begin
      conv_rate <= rate_select;
      conv_turbo <= turbo_mode;
    end
  end

  // oscillator and analog off when idle; sources stay on unless powered down
  assign analog_power_en = cst_q != AUC_C_SLEEP;
  assign osc_en = cst_q != AUC_C_SLEEP;
  assign excitation_current_source_en = ~pd_q;

  // ---------------------------------------------------------------
  // modulator clock
  // ---------------------------------------------------------------
  logic [24:0] macc_q;
  logic [24:0] msum;

  // fractional divider: 256 kHz normal, 512 kHz turbo
  assign msum = macc_q + (conv_turbo ? 25'(`AUC_FMOD_TURBO_HZ) : 25'(`AUC_FMOD_NORM_HZ));

  always_ff @(posedge clk) begin
    if (rst_all) begin
      macc_q <= '0;
      mod_tick <= 1'b0;
    end else if (msum >= 25'(`AUC_CLK_HZ)) begin
      macc_q <= msum - 25'(`AUC_CLK_HZ);
      mod_tick <= 1'b1;
    end else begin
      macc_q <= msum;
      mod_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // result buffer, ready flag and transmit queue
  // ---------------------------------------------------------------
  logic [15:0] res_q;
  logic result_ready_n_q;
  logic [5:0] pulse_q;
  logic [15:0] tx_buf_q;
  logic [1:0] tx_pend_q;
  logic rreg_wait_q;
  logic tx_ready;
  logic tx_go;
  logic auto_ld;

  assign tx_go = (tx_pend_q != 2'd0) & tx_ready;
  assign auto_ld = auto_read & ~result_ready_n_q & (pulse_q == 6'd0) & (tx_pend_q == 2'd0) & tx_ready;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      res_q <= 16'h0000;
      result_ready_n_q <= 1'b1;
      pulse_q <= 6'd0;
      tx_buf_q <= 16'h0000;
      tx_pend_q <= 2'd0;
      rreg_wait_q <= 1'b0;
    end else begin
      rreg_wait_q <= reg_rd.stb;
      if (tx_go) begin
        tx_buf_q <= {8'h00, tx_buf_q[15:8]}; // low byte first
        tx_pend_q <= tx_pend_q - 2'd1;
      end
      if (pulse_q != 6'd0) begin
        pulse_q <= pulse_q - 6'd1;
        result_ready_n_q <= pulse_q != 6'd1;
      end
      if (conv_result.done) begin
        res_q <= conv_result.data; // two's complement word
        if (!result_ready_n_q && cm_act_q && !auto_read) begin
          pulse_q <= 6'(PULSE_CYC); // unread: brief high first
          result_ready_n_q <= 1'b1;
        end else begin
          result_ready_n_q <= 1'b0;
        end
      end else if (rdata_q || auto_ld) begin
        tx_buf_q <= res_q;
        tx_pend_q <= 2'd2;
        result_ready_n_q <= 1'b1; // latched for output
        pulse_q <= 6'd0;
      end else if (rreg_wait_q) begin
        tx_buf_q <= {8'h00, reg_rd_data};
        tx_pend_q <= 2'd1;
      end
    end
  end

  auc_tx #(.CW(CW)) u_tx (
    .clk(clk),
    .rst(rst_all),
    .bit_len(bit_q),
    .go(tx_go),
    .byte_in(tx_buf_q[7:0]),
    .ready(tx_ready),
    .txd(tx_pin)
  );

  // shared pin: ready flag only when output and selected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      general_io_pin_two_o <= 1'b0;
    end else begin
      general_io_pin_two_o <= shared_pin_function_select ? result_ready_n_q : general_io_pin_two_out;
    end
  end

  assign general_io_pin_two_oe = general_io_pin_two_dir;
  assign result_ready_n = result_ready_n_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_all);

  sequence s_delay_end;
    cst_q == AUC_C_DELAY && dly_q == dly_lim - 11'd1 && !start_cmd_q && !sleep_cmd_q;
  endsequence

  start_delay_a: assert property (s_delay_end |=> conv_start && cst_q == AUC_C_RUN)
    else $error("continuous start delay not honoured");
  one_shot_a: assert property (cst_q == AUC_C_RUN
    && conv_result.done && !cm_act_q && !wr_restart && !start_cmd_q && !sleep_cmd_q
    |=> cst_q == AUC_C_SLEEP && !conv_start)
    else $error("single-shot did not return to low power");
  cont_again_a: assert property (cst_q == AUC_C_RUN && conv_result.done && cm_act_q
    && !sleep_pend_q && !start_cmd_q && !sleep_cmd_q |=> conv_start)
    else $error("continuous conversion did not restart");
  write_restart_a: assert property (cst_q == AUC_C_RUN && wr_restart
    && !start_cmd_q && !sleep_cmd_q |=> conv_start && cst_q == AUC_C_RUN)
    else $error("register write did not restart conversion");
  sleep_power_a: assert property (pd_q |-> !analog_power_en
    && !excitation_current_source_en)
    else $error("analog powered while asleep");
  result_ready_n_latch_a: assert property (rdata_q && !conv_result.done |=> result_ready_n
    && tx_pend_q == 2'd2 && tx_buf_q == $past(res_q))
    else $error("ready flag not raised on latch");
  tx_idle_a: assert property (tx_ready && tx_pend_q == 2'd0 |=> tx_pin)
    else $error("transmit line low while idle");
  rx_timeout_a: assert property (to_hit |=> rst_q == AUC_R_IDLE && !rx_stb_q)
    else $error("timeout did not reset receiver");
  unread_pulse_a: assert property (conv_result.done && !result_ready_n_q && cm_act_q && !auto_read
    |=> result_ready_n ##1 result_ready_n)
    else $error("unread result pulse missing");
endmodule
`default_nettype wire

// file: sim/auc_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------
// host uart model
// ----------------
module auc_host #(
  parameter int BC = 16
) (
  input wire logic clk,
  output logic rxd,
  input wire logic txd
);
  initial rxd = 1'b1; // line idles high between frames
  // start, eight bits lsb first, stop; only the host drives rx
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      repeat (BC) @(posedge clk);
      #1;
    end
  endtask
  // the sync word comes first every time
  task automatic cmd(input logic [7:0] c);
    send(8'h55);
    send(c);
  endtask
  // sample at bit middles; ok drops on no start or low stop
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    ok = n < 3000;
    repeat (BC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge clk);
      b[i] = txd;
    end
    repeat (BC) @(posedge clk);
    ok = ok && txd === 1'b1;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import auc_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, rx, tx, mode = 1'b0, turbo = 1'b0, sel = 1'b1;
  logic cs, ape, osc, exc, tick, rdy_n, gp_o, gpo = 1'b0;
  logic pin_n = 1'b1, auto = 1'b0, dir = 1'b1, oe, c_turbo, cfg_rst;
  logic [7:0] rdv = 8'h00;
  auc_reg_req_t wr_o, rd_o;
  logic [2:0] rate = 3'h0, rate_o;
  auc_result_t res = '0;
  int mismatches = 0, tests_run = 0, cyc = 0, starts = 0, ticks = 0;
  // ----------------
  // clock, counters
  // ----------------
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    starts += int'(cs);
    ticks += int'(tick);
    if (cyc == 40000) begin
      mismatches++;
      wrap_up();
    end
  end
  auc_host host (.clk(clk), .rxd(rx), .txd(tx));
  auc_ctrl #(.TO_NORM_CYC(2000), .TO_TURBO_CYC(2000)) dut (.clk(clk), .sys_rst(sys_rst),
    .reset_pin_n(pin_n), .rx_pin(rx), .tx_pin(tx), .conversion_mode_select(mode),
    .turbo_mode(turbo), .auto_read(auto), .rate_select(rate), .general_io_pin_two_dir(dir),
    .general_io_pin_two_out(gpo), .shared_pin_function_select(sel), .conv_result(res), .conv_start(cs),
    .conv_rate(rate_o), .conv_turbo(c_turbo), .analog_power_en(ape), .osc_en(osc),
    .excitation_current_source_en(exc), .mod_tick(tick), .result_ready_n(rdy_n),
    .general_io_pin_two_o(gp_o), .general_io_pin_two_oe(oe), .reg_wr(wr_o), .reg_rd(rd_o),
    .reg_rd_data(rdv), .cfg_reset(cfg_rst));
  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle finished conversion carrying a random code
  task automatic done(output logic [15:0] d);
    d = 16'($urandom);
    res = {1'b1, d};
    step(1);
    res = '0;
  endtask
  // latch-to-first-start gap, cycles
  function automatic int gap(input logic t);
    return t ? 1282 : 696;
  endfunction
  // modulator ticks in 2000 cycles
  function automatic int exp_ticks(input logic t);
    return (t ? 512 : 256) * 80 / 1000;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [15:0] d, q;
    logic ok, ok2;
    logic [7:0] w;
    int s0, t0, a;
    void'($urandom(255));
    step(3);
    sys_rst = 1'b0;
    check(tx, 1, "tx idle");
    // single shot with both start encodings, then manual read
    for (int k = 0; k < 2; k++) begin
      rate = 3'($urandom);
      s0 = starts;
      host.cmd(8'h08 | 8'(k));
      step(4);
      check(16'(starts - s0), 1, "one start");
      check(rate_o, rate, "rate copy");
      done(d);
      step(2);
      check({ape, osc, exc, rdy_n, gp_o}, 5'b00100, "idle after one");
      // a lone sync byte must time out, or the read below is misframed
      if (k == 1) begin
        host.send(8'h55);
        step(2100);
      end
      fork
        host.cmd(8'h10 | 8'($urandom % 16));
        begin
          host.recv(q[7:0], ok);
          host.recv(q[15:8], ok2);
        end
      join
      check(q, d, "result word");
      check({ok, ok2, rdy_n}, 3'b111, "frames and flag");
      check(16'(starts - s0), 1, "no rerun");
    end
    // continuous in normal then turbo
    for (int k = 0; k < 2; k++) begin
      turbo = k[0];
      mode = 1'b1;
      s0 = starts;
      host.cmd(8'h09);
      t0 = cyc;
      while (starts == s0 && cyc < t0 + 2000) step(1);
      check(16'((cyc - t0 - gap(turbo)) inside {[-6:6]}), 1, "start delay");
      check(ape, 1, "woken");
      t0 = ticks;
      step(2000);
      a = ticks - t0;
      check(16'(a inside {[exp_ticks(turbo):exp_ticks(turbo) + 1]}), 1, "tick rate");
      check(c_turbo, turbo, "speed copy");
      s0 = starts;
      done(d);
      step(3);
      check(16'(starts - s0), 1, "back to back");
      done(d);
      step(3);
      check(rdy_n, 1, "unread pulse");
      step(55);
      check(rdy_n, 0, "ready again");
      // register write restarts unless it targets 04h
      for (int j = 0; j < 2; j++) begin
        a = j ? 4 : $urandom % 4;
        s0 = starts;
        host.cmd(8'h40 | 8'(a << 1));
        w = 8'($urandom);
        host.send(w);
        step(4);
        check(16'(starts - s0), 16'(a != 4), "write restart");
        check({wr_o.addr, wr_o.data}, {3'(a), w}, "write fields");
      end
      s0 = starts;
      host.cmd(8'h02 | 8'($urandom % 2));
      step(4);
      check({ape, exc}, 2'b11, "finishing");
      done(d);
      step(3);
      check({ape, exc, 14'(starts - s0)}, 16'h0, "powered down");
    end
    // register read answers with the forwarded value
    a = $urandom % 8;
    rdv = 8'($urandom);
    fork
      host.cmd(8'h20 | 8'(a << 1));
      host.recv(q[7:0], ok);
    join
    step(1);
    check({ok, rd_o.addr, q[7:0]}, {1'b1, 3'(a), rdv}, "register read");
    // automatic read: result leaves without a command
    auto = 1'b1;
    fork
      done(d);
      begin
        host.recv(q[7:0], ok);
        host.recv(q[15:8], ok2);
      end
    join
    step(2);
    auto = 1'b0;
    check(q, d, "auto read");
    check({ok, ok2, rdy_n}, 3'b111, "auto frames");
    // pin reset while powered down, then the host waits before talking
    pin_n = 1'b0;
    step(8);
    check({exc, cfg_rst}, 2'b11, "pin reset");
    pin_n = 1'b1;
    step(8);
    check(cfg_rst, 0, "pin released");
    // reset command drops a pending continuous start
    host.cmd(8'h08);
    step(2);
    check(ape, 1, "armed");
    host.cmd(8'h06 | 8'($urandom % 2));
    step(8);
    check({ape, osc, rdy_n}, 3'b001, "command reset");
    sel = 1'b0;
    gpo = 1'b1;
    dir = 1'($urandom);
    step(3);
    check({gp_o, oe}, {1'b1, dir}, "gpio routed");
    wrap_up();
  end
endmodule
`default_nettype wire
